// ===== hw/i2c_master_transmitter.sv
// two-wire bus master transmitter with transmit byte fifo
`timescale 1ns/1ps

// --------------------------------------------------------------------------
// synchronous fifo
// --------------------------------------------------------------------------
module tx_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_flush,
   input wire logic i_wr_valid,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic o_wr_ready,
   output logic o_rd_valid,
   output logic [WIDTH-1:0] o_rd_data,
   input wire logic i_rd_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
      (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   wire empty = (wr_ptr_reg == rd_ptr_reg);
   wire do_wr = i_wr_valid && !full;
   wire do_rd = i_rd_ready && !empty;

   assign o_wr_ready = !full;
   assign o_rd_valid = !empty;
   assign o_rd_data = mem[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge i_clk_sys) begin
      if (do_wr) begin
         mem[wr_ptr_reg[AW-1:0]] <= i_wr_data;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else if (i_flush) begin
         rd_ptr_reg <= wr_ptr_reg;
      end else begin
         if (do_wr) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule

// --------------------------------------------------------------------------
// master transmitter top
// --------------------------------------------------------------------------
module i2c_master_transmitter #(
   parameter int FIFO_DEPTH = i2c_mt_pkg::FIFO_DEPTH
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_wire_clock_pin,
   output logic o_wire_clock_pin,
   output logic o_wire_clock_pin_oe,
   input wire logic i_wire_data_pin,
   output logic o_wire_data_pin,
   output logic o_wire_data_pin_oe,
   input wire logic [i2c_mt_pkg::ADDR_W-1:0] i_target_device_address,
   input wire logic i_read_direction_select,
   input wire logic [i2c_mt_pkg::PRE_W-1:0] i_clock_prescale,
   input wire logic [i2c_mt_pkg::DIV_W-1:0] i_clock_high_divider,
   input wire logic [i2c_mt_pkg::DIV_W-1:0] i_clock_low_divider,
   input wire logic i_slave_disable,
   input wire logic i_master_enable,
   input wire logic i_thr_valid,
   input wire logic [i2c_mt_pkg::BYTE_BITS-1:0] i_thr_data,
   output logic o_thr_ready,
   input wire logic i_stop_cmd,
   input wire logic i_status_read,
   input wire logic i_int_en_no_ack_flag,
   input wire logic i_int_en_transmit_ready_flag,
   input wire logic i_int_en_arb,
   output logic o_no_ack_flag,
   output logic o_transmit_ready_flag,
   output logic o_arb_lost_flag,
   output logic o_slave_mode,
   output logic o_busy,
   output logic o_dma_tx_request,
   output logic o_irq
);
   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic scl_meta_reg, scl_s_reg, sda_meta_reg, sda_s_reg;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_meta_reg <= 1'b1;
         scl_s_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_s_reg <= 1'b1;
      end else begin
         scl_meta_reg <= i_wire_clock_pin;
         scl_s_reg <= scl_meta_reg;
         sda_meta_reg <= i_wire_data_pin;
         sda_s_reg <= sda_meta_reg;
      end
   end

   // ----------------------------------------------------------------------
   // state and datapath registers
   // ----------------------------------------------------------------------
   i2c_mt_pkg::seq_state_t state_reg, state_next;
   logic [i2c_mt_pkg::TMR_W-1:0] tmr_reg;
   logic [3:0] bit_cnt_reg;
   logic [i2c_mt_pkg::BYTE_BITS-1:0] shreg_reg;
   logic stop_pend_reg, no_ack_flag_reg, transmit_ready_flag_reg, arb_reg, slave_reg;
   logic scl_oe_reg, sda_oe_reg;

   // ----------------------------------------------------------------------
   // fifo in front of the shifter
   // ----------------------------------------------------------------------
   wire fifo_vld;
   wire [i2c_mt_pkg::BYTE_BITS-1:0] fifo_data;
   wire fifo_pop;
   wire no_ack_flag_ev;
   wire thr_wr = i_thr_valid && o_thr_ready;

   tx_byte_fifo #(
      .WIDTH(i2c_mt_pkg::BYTE_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_flush(no_ack_flag_ev),
      .i_wr_valid(i_thr_valid),
      .i_wr_data(i_thr_data),
      .o_wr_ready(o_thr_ready),
      .o_rd_valid(fifo_vld),
      .o_rd_data(fifo_data),
      .i_rd_ready(fifo_pop)
   );

   // ----------------------------------------------------------------------
   // phase lengths, floored to the fastest legal bit rate
   // ----------------------------------------------------------------------
   wire [i2c_mt_pkg::TMR_W-1:0] lo_raw =
      i2c_mt_pkg::TMR_W'(i_clock_low_divider) << i_clock_prescale;
   wire [i2c_mt_pkg::TMR_W-1:0] hi_raw =
      i2c_mt_pkg::TMR_W'(i_clock_high_divider) << i_clock_prescale;
   wire [i2c_mt_pkg::TMR_W-1:0] lo_ph =
      (lo_raw < i2c_mt_pkg::MIN_HALF) ? i2c_mt_pkg::MIN_HALF : lo_raw;
   wire [i2c_mt_pkg::TMR_W-1:0] hi_ph =
      (hi_raw < i2c_mt_pkg::MIN_HALF) ? i2c_mt_pkg::MIN_HALF : hi_raw;

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   wire tmr_zero = (tmr_reg == i2c_mt_pkg::TMR_RST);
   wire hi_wait = (state_reg == i2c_mt_pkg::ST_START) ||
      (state_reg == i2c_mt_pkg::ST_HIGH) ||
      (state_reg == i2c_mt_pkg::ST_STOP_HIGH) ||
      (state_reg == i2c_mt_pkg::ST_STOP_END);
   wire phase_end = tmr_zero && (!hi_wait || scl_s_reg);
   wire hi_end = (state_reg == i2c_mt_pkg::ST_HIGH) && phase_end;
   wire ack_slot = (bit_cnt_reg == i2c_mt_pkg::ACK_SLOT);
   wire ack_ev = hi_end && ack_slot && !sda_s_reg;
   assign no_ack_flag_ev = hi_end && ack_slot && sda_s_reg;
   wire arb_ev = hi_end && !ack_slot && shreg_reg[7] && !sda_s_reg;
   wire bus_free = scl_s_reg && sda_s_reg;
   wire can_start = i_master_enable && i_slave_disable && fifo_vld &&
      bus_free;
   assign fifo_pop = fifo_vld && (ack_ev ||
      (state_reg == i2c_mt_pkg::ST_HOLD));
   wire load_byte = fifo_pop;

   // lines driven low, never high
   wire scl_drv = (state_reg == i2c_mt_pkg::ST_LOW) ||
      (state_reg == i2c_mt_pkg::ST_HOLD) ||
      (state_reg == i2c_mt_pkg::ST_STOP_LOW);
   wire sda_drv = (state_reg == i2c_mt_pkg::ST_START) ||
      (state_reg == i2c_mt_pkg::ST_STOP_LOW) ||
      (state_reg == i2c_mt_pkg::ST_STOP_HIGH) ||
      (((state_reg == i2c_mt_pkg::ST_LOW) ||
        (state_reg == i2c_mt_pkg::ST_HIGH)) &&
       !ack_slot && !shreg_reg[7]);

   // ----------------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         i2c_mt_pkg::ST_IDLE: begin
            if (can_start) begin
               state_next = i2c_mt_pkg::ST_START;
            end
         end
         i2c_mt_pkg::ST_START: begin
            if (phase_end) begin
               state_next = i2c_mt_pkg::ST_LOW;
            end
         end
         i2c_mt_pkg::ST_LOW: begin
            if (phase_end) begin
               state_next = i2c_mt_pkg::ST_HIGH;
            end
         end
         i2c_mt_pkg::ST_HIGH: begin
            if (arb_ev) begin
               state_next = i2c_mt_pkg::ST_IDLE;
            end else if (no_ack_flag_ev) begin
               state_next = i2c_mt_pkg::ST_STOP_LOW;
            end else if (hi_end && !ack_slot) begin
               state_next = i2c_mt_pkg::ST_LOW;
            end else if (ack_ev && fifo_pop) begin
               state_next = i2c_mt_pkg::ST_LOW;
            end else if (ack_ev && stop_pend_reg) begin
               state_next = i2c_mt_pkg::ST_STOP_LOW;
            end else if (ack_ev) begin
               state_next = i2c_mt_pkg::ST_HOLD;
            end
         end
         i2c_mt_pkg::ST_HOLD: begin
            if (fifo_vld) begin
               state_next = i2c_mt_pkg::ST_LOW;
            end else if (stop_pend_reg) begin
               state_next = i2c_mt_pkg::ST_STOP_LOW;
            end
         end
         i2c_mt_pkg::ST_STOP_LOW: begin
            if (phase_end) begin
               state_next = i2c_mt_pkg::ST_STOP_HIGH;
            end
         end
         i2c_mt_pkg::ST_STOP_HIGH: begin
            if (phase_end) begin
               state_next = i2c_mt_pkg::ST_STOP_END;
            end
         end
         i2c_mt_pkg::ST_STOP_END: begin
            if (phase_end) begin
               state_next = i2c_mt_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = i2c_mt_pkg::ST_IDLE;
         end
      endcase
   end

   wire state_chg = (state_next != state_reg);
   wire next_lo = (state_next == i2c_mt_pkg::ST_LOW) ||
      (state_next == i2c_mt_pkg::ST_STOP_LOW);
   wire [i2c_mt_pkg::TMR_W-1:0] tmr_load = next_lo ? lo_ph : hi_ph;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= i2c_mt_pkg::ST_IDLE;
         tmr_reg <= i2c_mt_pkg::TMR_RST;
      end else begin
         state_reg <= state_next;
         if (state_chg) begin
            tmr_reg <= tmr_load;
         end else if (!tmr_zero && (!hi_wait || scl_s_reg)) begin
            tmr_reg <= tmr_reg - 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // shifter: address plus direction first, then data bytes
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shreg_reg <= i2c_mt_pkg::SHIFT_RST;
         bit_cnt_reg <= i2c_mt_pkg::BIT_CNT_RST;
      end else if (state_reg == i2c_mt_pkg::ST_IDLE && can_start) begin
         shreg_reg <= {i_target_device_address,
                       i_read_direction_select};
         bit_cnt_reg <= i2c_mt_pkg::BIT_CNT_RST;
      end else if (load_byte) begin
         shreg_reg <= fifo_data;
         bit_cnt_reg <= i2c_mt_pkg::BIT_CNT_RST;
      end else if (hi_end && !ack_slot) begin
         shreg_reg <= {shreg_reg[6:0], 1'b1};
         bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // status flags, set wins over clear
   // ----------------------------------------------------------------------
   wire stop_take = state_chg && (state_next == i2c_mt_pkg::ST_STOP_LOW);
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stop_pend_reg <= 1'b0;
         no_ack_flag_reg <= 1'b0;
         transmit_ready_flag_reg <= 1'b0;
         arb_reg <= 1'b0;
         slave_reg <= 1'b0;
      end else begin
         stop_pend_reg <= (i_stop_cmd && o_busy) ||
            (stop_pend_reg && !stop_take);
         no_ack_flag_reg <= no_ack_flag_ev || (no_ack_flag_reg && !i_status_read);
         transmit_ready_flag_reg <= ack_ev || (transmit_ready_flag_reg && !thr_wr);
         arb_reg <= arb_ev || (arb_reg && !i_status_read);
         slave_reg <= arb_ev || (slave_reg && !can_start);
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   // data waits one cycle after the clock falls, so no false start/stop
   wire sda_hold = ((state_reg == i2c_mt_pkg::ST_LOW) ||
      (state_reg == i2c_mt_pkg::ST_STOP_LOW)) && !scl_oe_reg;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else begin
         scl_oe_reg <= scl_drv;
         sda_oe_reg <= sda_hold ? sda_oe_reg : sda_drv;
      end
   end

   assign o_wire_clock_pin = 1'b0;
   assign o_wire_data_pin = 1'b0;
   assign o_wire_clock_pin_oe = scl_oe_reg;
   assign o_wire_data_pin_oe = sda_oe_reg;
   assign o_no_ack_flag = no_ack_flag_reg;
   assign o_transmit_ready_flag = transmit_ready_flag_reg;
   assign o_arb_lost_flag = arb_reg;
   assign o_slave_mode = slave_reg;
   assign o_busy = (state_reg != i2c_mt_pkg::ST_IDLE);
   assign o_dma_tx_request = transmit_ready_flag_reg;
   assign o_irq = (no_ack_flag_reg && i_int_en_no_ack_flag) ||
      (transmit_ready_flag_reg && i_int_en_transmit_ready_flag) || (arb_reg && i_int_en_arb);

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   property p_idle_released;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      state_reg == i2c_mt_pkg::ST_IDLE ##1 state_reg == i2c_mt_pkg::ST_IDLE
         |-> !o_wire_clock_pin_oe && !o_wire_data_pin_oe;
   endproperty
   a_idle_released: assert property (p_idle_released)
      else $error("bus not released while idle");

   property p_start_shape;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      state_reg == i2c_mt_pkg::ST_START |-> sda_drv && !scl_drv;
   endproperty
   a_start_shape: assert property (p_start_shape)
      else $error("start not data low with clock released");

   property p_stop_shape;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      state_reg == i2c_mt_pkg::ST_STOP_HIGH &&
         state_next == i2c_mt_pkg::ST_STOP_END
         |=> !sda_drv && !scl_drv && $past(sda_drv);
   endproperty
   a_stop_shape: assert property (p_stop_shape)
      else $error("stop not data rise with clock released");

   property p_addr_load;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      state_reg == i2c_mt_pkg::ST_IDLE && can_start
         |=> state_reg == i2c_mt_pkg::ST_START &&
         shreg_reg == {$past(i_target_device_address),
                       $past(i_read_direction_select)};
   endproperty
   a_addr_load: assert property (p_addr_load)
      else $error("address and direction not loaded at start");

   property p_ack_release;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (state_reg == i2c_mt_pkg::ST_LOW ||
       state_reg == i2c_mt_pkg::ST_HIGH) && ack_slot |-> !sda_drv;
   endproperty
   a_ack_release: assert property (p_ack_release)
      else $error("data driven during acknowledge slot");

   property p_no_ack_flag_flag;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      hi_end && ack_slot && sda_s_reg
         |=> o_no_ack_flag && state_reg == i2c_mt_pkg::ST_STOP_LOW;
   endproperty
   a_no_ack_flag_flag: assert property (p_no_ack_flag_flag)
      else $error("missing ack not flagged or stop not begun");

   property p_transmit_ready_flag_hold;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_transmit_ready_flag && !thr_wr |=> o_transmit_ready_flag;
   endproperty
   a_transmit_ready_flag_hold: assert property (p_transmit_ready_flag_hold)
      else $error("transmit ready dropped without a write");

   property p_hold_low;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      state_reg == i2c_mt_pkg::ST_HOLD && !fifo_vld && !stop_pend_reg
         |=> o_wire_clock_pin_oe;
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("clock released while stretching");

   property p_stop_cause;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      stop_take |-> stop_pend_reg || no_ack_flag_ev;
   endproperty
   a_stop_cause: assert property (p_stop_cause)
      else $error("stop without command or missing ack");

   property p_irq_mask;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !i_int_en_no_ack_flag && !i_int_en_transmit_ready_flag && !i_int_en_arb |-> !o_irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("interrupt raised with all sources masked");

   property p_arb_slave;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      arb_ev |=> o_slave_mode && state_reg == i2c_mt_pkg::ST_IDLE;
   endproperty
   a_arb_slave: assert property (p_arb_slave)
      else $error("lost arbitration did not drop to slave");

   property p_low_len;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(state_reg == i2c_mt_pkg::ST_LOW) |-> tmr_reg >= i2c_mt_pkg::MIN_HALF;
   endproperty
   a_low_len: assert property (p_low_len)
      else $error("clock low phase shorter than rate limit");
endmodule

// ===== hw/i2c_mt_pkg.sv
// constants and state type for the two-wire master transmitter
package i2c_mt_pkg;
   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 25000;
   localparam int MAX_RATE_KBPS = 400;
   localparam int BIT_PERIOD_PS = 1000000000 / MAX_RATE_KBPS;
   localparam int MIN_HALF_CYC =
      (BIT_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // ----------------------------------------------------------------------
   // widths and counts
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 7;
   localparam int DIV_W = 8;
   localparam int PRE_W = 3;
   localparam int TMR_W = 16;
   localparam int BYTE_BITS = 8;
   localparam int FIFO_DEPTH = 16;
   localparam logic [TMR_W-1:0] MIN_HALF = TMR_W'(MIN_HALF_CYC);
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] BIT_CNT_RST = 4'h0;
   localparam logic [BYTE_BITS-1:0] SHIFT_RST = 8'hff;
   localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
   // ----------------------------------------------------------------------
   // bus sequencer states, gray along start, bits, hold, stop
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_START = 3'h1,
      ST_LOW = 3'h3,
      ST_HIGH = 3'h2,
      ST_HOLD = 3'h6,
      ST_STOP_LOW = 3'h7,
      ST_STOP_HIGH = 3'h5,
      ST_STOP_END = 3'h4
   } seq_state_t;
endpackage

// ===== tb/i2c_slave_model.sv
// behavioural open-drain bus slave that records bytes and acknowledges
`timescale 1ns/1ps
module i2c_slave_model (
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_no_ack_flag,
   output logic o_sda_oe
);
   logic [7:0] shift_reg;
   int bit_cnt;
   int starts;
   int stops;
   logic [7:0] rx_q[$];
   initial begin
      o_sda_oe = 1'b0;
      bit_cnt = 0;
      starts = 0;
      stops = 0;
   end
   always @(negedge i_sda) if (i_scl) begin
      starts++;
      bit_cnt = 0;
   end
   always @(posedge i_sda) if (i_scl && starts > stops) stops++;
   always @(posedge i_scl) begin
      if (bit_cnt < 8) begin
         shift_reg = {shift_reg[6:0], i_sda};
         bit_cnt++;
      end else begin
         bit_cnt = 0;
      end
   end
   // only ever pulls low, in the ninth slot
   always @(negedge i_scl) begin
      if (bit_cnt == 8) begin
         rx_q.push_back(shift_reg);
         o_sda_oe = !i_no_ack_flag;
      end else begin
         o_sda_oe = 1'b0;
      end
   end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the two-wire master transmitter
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
   errors++; $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module tb_top;
   logic i_clk_sys = 0, i_rst_n = 0, no_ack_flag = 0;
   logic scl_oe, sda_oe, slv_oe, scl_o, sda_o, thr_ready, stop_cmd = 0;
   logic thr_valid = 0, status_read = 0, int_en = 0, master_en = 0;
   logic [7:0] thr_data = 8'h00, div_h = 8'h00, div_l = 8'h00;
   logic [6:0] addr = 7'h00;
   logic [2:0] pre = 3'h0;
   logic no_ack, tx_rdy, busy, dma, irq, arb, slv_mode;
   logic [7:0] exp_q[$];
   int errors = 0, compares = 0, cycles = 0, i;
   wire scl = !scl_oe;
   wire sda = !(sda_oe | slv_oe);
   initial forever #12.5 i_clk_sys = !i_clk_sys;
   i2c_master_transmitter dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
      .i_wire_clock_pin(scl), .o_wire_clock_pin(scl_o),
      .o_wire_clock_pin_oe(scl_oe), .i_wire_data_pin(sda),
      .o_wire_data_pin(sda_o), .o_wire_data_pin_oe(sda_oe),
      .i_target_device_address(addr), .i_read_direction_select(1'b0),
      .i_clock_prescale(pre), .i_clock_high_divider(div_h),
      .i_clock_low_divider(div_l), .i_slave_disable(1'b1),
      .i_master_enable(master_en), .i_thr_valid(thr_valid),
      .i_thr_data(thr_data), .o_thr_ready(thr_ready),
      .i_stop_cmd(stop_cmd), .i_status_read(status_read),
      .i_int_en_no_ack_flag(int_en), .i_int_en_transmit_ready_flag(1'b0), .i_int_en_arb(1'b0),
      .o_no_ack_flag(no_ack), .o_transmit_ready_flag(tx_rdy),
      .o_arb_lost_flag(arb), .o_slave_mode(slv_mode), .o_busy(busy),
      .o_dma_tx_request(dma), .o_irq(irq));
   i2c_slave_model slave (.i_scl(scl), .i_sda(sda), .i_no_ack_flag(no_ack_flag),
      .o_sda_oe(slv_oe));
   function automatic logic [7:0] addr_byte(logic [6:0] a);
      return {a, 1'b0};
   endfunction
   task automatic summarize();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic push(logic [7:0] b);
      @(posedge i_clk_sys);
      #2 thr_valid = 1'b1;
      thr_data = b;
      exp_q.push_back(b);
      @(posedge i_clk_sys);
      #2 thr_valid = 1'b0;
   endtask
   task automatic pulse_stop();
      @(posedge i_clk_sys);
      #2 stop_cmd = 1'b1;
      @(posedge i_clk_sys);
      #2 stop_cmd = 1'b0;
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (3) @(posedge i_clk_sys);
      while (busy !== 1'b0 && n < 25000) begin
         @(posedge i_clk_sys);
         n++;
      end
      #2 `CHK("busy", 1'b0, busy)
   endtask
   always @(posedge i_clk_sys) begin
      cycles++;
      `CHK("drive level", 2'b00, {scl_o, sda_o})
      if (cycles == 80000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      void'($urandom(53405));
      repeat (10) @(posedge i_clk_sys);
      #2 i_rst_n = 1'b1;
      `CHK("idle lines", 2'b00, {scl_oe, sda_oe})
      addr = 7'($urandom);
      pre = 3'($urandom % 2);
      div_h = 8'($urandom % 16);
      div_l = 8'($urandom % 16);
      master_en = 1'b1;
      exp_q.push_back(addr_byte(addr));
      push(8'h80);
      push(8'($urandom));
      push(8'($urandom));
      pulse_stop();
      wait_idle();
      `CHK("tx ready", 1'b1, tx_rdy)
      `CHK("dma", 1'b1, dma)
      exp_q.push_back(addr_byte(addr));
      push(8'($urandom));
      repeat (3000) @(posedge i_clk_sys);
      `CHK("clock held", 2'b01, {scl, busy})
      push(8'h01);
      pulse_stop();
      wait_idle();
      master_en = 1'b0;
      exp_q.push_back(addr_byte(addr));
      for (i = 0; i < 16; i++) push(8'($urandom));
      `CHK("fifo full", 1'b0, thr_ready)
      master_en = 1'b1;
      repeat (2000) @(posedge i_clk_sys);
      pulse_stop();
      wait_idle();
      no_ack_flag = 1'b1;
      exp_q.push_back(addr_byte(addr));
      push(8'($urandom));
      void'(exp_q.pop_back());
      wait_idle();
      `CHK("no ack", 1'b1, no_ack)
      `CHK("irq masked", 1'b0, irq)
      #25 int_en = 1'b1;
      #25 `CHK("irq enabled", 1'b1, irq)
      status_read = 1'b1;
      #25 status_read = 1'b0;
      `CHK("flag cleared", 1'b0, no_ack)
      `CHK("arb lost", 1'b0, arb)
      `CHK("slave mode", 1'b0, slv_mode)
      `CHK("starts", 4, slave.starts)
      `CHK("stops", 4, slave.stops)
      `CHK("rx count", exp_q.size(), slave.rx_q.size())
      for (i = 0; i < exp_q.size() && i < slave.rx_q.size(); i++)
         `CHK("rx byte", exp_q[i], slave.rx_q[i])
      summarize();
   end
endmodule
